// ### rtl/emts_top.sv
// Purpose: Reads an external multiturn sensor, loads and verifies the
//          internal turn counter, holds configuration and commands.
// Assumes: Wrap pulses and sync reference come from the local clock.
// Notes:   Status flags are sticky until cleared.
// Function
// [R01] Invert external turn direction when set
// [R02] Error bit field selects none, low, high
// [R03] Sensor has parity and warning bits off
// [R04] Frame length is data plus sync plus error
// [R05] Add static offset before synchronization
// [R06] Periodic verification when enable bit set
// [R07] Verify command triggers one verification
// [R08] Mismatch sets turn verify error status
// [R09] One to six low bits count singleturn
// [R10] Recommended master period pairings for two chips
// [R11] Host enables chain passthrough before sensor setup
// [R12] Host writes pending values before switching
// [R13] Switch failure reported in status word one
// [R14] Soft reset applies pending port settings
// [R15] Sync length selects one to four bits
// [R16] Startup read loads counter, retried on failure
// [R17] Frame shifted in MSB first
`timescale 1ns/1ns
module emts_top import emts_pkg::*; #(
  parameter int          VERIFY_PERIOD_NS = 1000000,
  parameter logic [15:0] LEGAL_MODES      = 16'h00FF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             ssi_clk_o,
  input  wire logic        ssi_data_i,
  input  wire logic        st_wrap_up_i,
  input  wire logic        st_wrap_dn_i,
  input  wire logic [3:0]  st_sync_ref_i,
  output logic [23:0]      turn_count_o,
  output logic [4:0]       st_bits_o,
  output logic             turn_valid_o,
  output logic             chain_passthrough_enable_o,
  output logic [3:0]       port_a_mode_o,
  output logic [1:0]       register_protect_level_o,
  output logic             irq_o
);
  // ------------------------------------------------------------
  // Elaboration checks and derived counts
  // ------------------------------------------------------------
  localparam int VERIFY_CYC = VERIFY_PERIOD_NS / CLK_NS;
  localparam int TW         = $clog2(VERIFY_CYC + 1);
  generate
    if (VERIFY_CYC < 1) begin : g_bad_period
      $error("verify period shorter than one clock");
    end
  endgenerate

  typedef enum logic [2:0] {
    FS_IDLE = 3'h1, FS_READ = 3'h2, FS_EVAL = 3'h4
  } emts_fsm_t;
  typedef struct packed {
    logic [7:0]        cfg0;
    logic [7:0]        cfg1;
    logic [7:0]        cfg2;
    logic [7:0]        pend;
    logic [7:0]        act;
    logic              armed;
    logic [3:0]        stat;
    logic [3:0]        ien;
    logic [TURN_W-1:0] turn;
    emts_fsm_t         fsm;
    logic              boot;
    logic              vreq;
    logic [TW-1:0]     tick;
    logic              start;
    logic              ack;
    logic [31:0]       rdata;
  } emts_top_t;
  emts_top_t q, d;

  emts_link_if link ();
  logic        sy_valid;
  logic [23:0] sy_value;
  logic        sy_err;

  // ------------------------------------------------------------
  // Decoded configuration
  // ------------------------------------------------------------
  logic [3:0] fmt;
  logic [1:0] err_sel;
  logic [4:0] dbits;
  logic [2:0] sbits;
  logic       ebit;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic [3:0] ev;
  logic       read_ok;

  assign fmt     = q.cfg2[B_FORMAT +: 4];
  assign err_sel = q.cfg0[B_ERR_SEL +: 2];
  assign dbits   = emts_fmt_bits(fmt);
  // [R15] sync bits one to four
  assign sbits   = 3'({1'b0, q.cfg2[B_SYNC +: 2]} + 3'h1);
  // [R02] reserved code reads no bit
  assign ebit    = (err_sel == ERR_LOW) || (err_sel == ERR_HIGH);
  assign idx     = wb_adr_i[9:2];
  assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~q.ack;
  assign rd      = wb_cyc_i & wb_stb_i & ~wb_we_i & ~q.ack;
  // [R03] parity and warning absent
  assign read_ok = (fmt != 4'h0) && !q.cfg2[B_CHAIN];
  // [R04] frame length sum
  assign link.len   = 5'(dbits + 5'(sbits) + 5'(ebit));
  assign link.start = q.start;

  emts_ssi_rx u_rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .link       (link.reader),
    .ssi_clk_o  (ssi_clk_o),
    .ssi_data_i (ssi_data_i)
  );

  emts_sync u_sync (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .valid_i    (link.done),
    .word_i     (link.word),
    .dbits_i    (dbits),
    .sbits_i    (sbits),
    .ebit_i     (ebit),
    .high_act_i (err_sel == ERR_HIGH),
    .inv_i      (q.cfg0[B_DIR_INV]),
    .ofs_i      (q.cfg1[B_OFFSET +: 4]),
    .ref_i      (st_sync_ref_i),
    .valid_o    (sy_valid),
    .value_o    (sy_value),
    .err_o      (sy_err)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.ack   = wb_cyc_i & wb_stb_i & ~q.ack;
    ev      = 4'h0;

    // Turn counter follows singleturn wraps
    if (st_wrap_up_i && !st_wrap_dn_i) begin
      d.turn = q.turn + 24'h000001;
    end else if (st_wrap_dn_i && !st_wrap_up_i) begin
      d.turn = q.turn - 24'h000001;
    end

    // [R06] periodic verify timer
    if (q.cfg2[B_PERIOD] && q.fsm == FS_IDLE && !q.boot) begin
      if (q.tick == TW'(VERIFY_CYC - 1)) begin
        d.tick = '0;
        d.vreq = 1'b1;
      end else begin
        d.tick = q.tick + TW'(1);
      end
    end else if (!q.cfg2[B_PERIOD]) begin
      d.tick = '0;
    end

    case (q.fsm)
      FS_IDLE: begin
        if (read_ok && !link.busy && (q.boot || q.vreq)) begin
          d.start = 1'b1;
          d.fsm   = FS_READ;
        end else if (!read_ok) begin
          d.vreq = 1'b0;
        end
      end
      FS_READ: begin
        if (link.done) begin
          d.fsm = FS_EVAL;
        end
      end
      FS_EVAL: begin
        if (sy_valid) begin
          d.fsm = FS_IDLE;
          if (q.boot) begin
            // [R16] load or retry
            if (sy_err) begin
              ev[S_RDERR] = 1'b1;
            end else begin
              d.turn         = sy_value;
              d.boot         = 1'b0;
              ev[S_LOADED]   = 1'b1;
            end
          end else begin
            d.vreq = 1'b0;
            // [R08] mismatch flags error
            if (sy_err) begin
              ev[S_RDERR] = 1'b1;
            end else if (sy_value != (q.turn & ((24'h1 << dbits) - 24'h1)))
            begin
              ev[S_VERR] = 1'b1;
            end
          end
        end
      end
      default: d.fsm = FS_IDLE;
    endcase

    // Register writes
    if (wr && wb_sel_i[0]) begin
      case (idx)
        IDX_CFG0: d.cfg0 = wb_dat_i[7:0];
        IDX_CFG1: d.cfg1 = wb_dat_i[7:0];
        IDX_CFG2: d.cfg2 = wb_dat_i[7:0];
        IDX_IEN:  d.ien  = wb_dat_i[3:0];
        // [R12] pending values staged
        IDX_PEND: d.pend = wb_dat_i[7:0];
        IDX_CLR:  d.stat = q.stat & ~wb_dat_i[3:0];
        IDX_CMD: begin
          // [R07] commanded verification
          if (wb_dat_i[C_VERIFY]) begin
            d.vreq = 1'b1;
          end
          // [R13] switch failure status
          if (wb_dat_i[C_SWITCH]) begin
            if (LEGAL_MODES[q.pend[B_MODE +: 4]]) begin
              d.armed = 1'b1;
            end else begin
              ev[S_SWERR] = 1'b1;
            end
          end
          // [R14] soft reset applies pending
          if (wb_dat_i[C_SOFTRST]) begin
            if (q.armed) begin
              d.act = q.pend;
            end
            d.armed = 1'b0;
            d.boot  = 1'b1;
            d.vreq  = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set wins over clear
    d.stat = d.stat | ev;

    // Read data
    d.rdata = 32'h00000000;
    if (rd) begin
      case (idx)
        IDX_CFG0: d.rdata = {24'h000000, q.cfg0};
        IDX_CFG1: d.rdata = {24'h000000, q.cfg1};
        IDX_CFG2: d.rdata = {24'h000000, q.cfg2};
        IDX_STAT: d.rdata = {28'h0000000, q.stat};
        IDX_IEN:  d.rdata = {28'h0000000, q.ien};
        IDX_PEND: d.rdata = {24'h000000, q.pend};
        IDX_ACT:  d.rdata = {24'h000000, q.act};
        IDX_TURN: d.rdata = {8'h00, q.turn};
        default:  d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.cfg0 <= REG_RST;
      q.cfg1 <= REG_RST;
      q.cfg2 <= REG_RST;
      q.pend <= REG_RST;
      q.act  <= REG_RST;
      q.fsm  <= FS_IDLE;
      q.boot <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wb_ack_o                   = q.ack;
  assign wb_dat_o                   = q.rdata;
  assign turn_count_o               = q.turn;
  // [R09] [R10] singleturn bits from frame
  assign st_bits_o                  = emts_st_bits(fmt);
  assign turn_valid_o               = ~q.boot;
  assign chain_passthrough_enable_o = q.cfg2[B_CHAIN];
  assign port_a_mode_o              = q.act[B_MODE +: 4];
  assign register_protect_level_o   = q.act[B_PROT +: 2];
  assign irq_o                      = |(q.stat & q.ien);
endmodule

// ### rtl/emts_pkg.sv
// Purpose: Shared constants, field layout and helpers of the external
//          multiturn reader.
// Assumes: Registers other than the 24-bit turn counter are at most 8 bits wide, one per aligned 32-bit word.
// Notes:   Byte address of a register is four times its index.
package emts_pkg;
  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CFG0 = 8'h0E;
  localparam logic [7:0] IDX_CFG1 = 8'h0F;
  localparam logic [7:0] IDX_CFG2 = 8'h10;
  localparam logic [7:0] IDX_CMD  = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;
  localparam logic [7:0] IDX_CLR  = 8'h22;
  localparam logic [7:0] IDX_IEN  = 8'h23;
  localparam logic [7:0] IDX_PEND = 8'h24;
  localparam logic [7:0] IDX_ACT  = 8'h25;
  localparam logic [7:0] IDX_TURN = 8'h26;
  // ------------------------------------------------------------
  // Field positions, codes and reset values
  // ------------------------------------------------------------
  localparam int B_DIR_INV = 5;
  localparam int B_ERR_SEL = 6;
  localparam int B_OFFSET  = 4;
  localparam int B_FORMAT  = 0;
  localparam int B_SYNC    = 4;
  localparam int B_PERIOD  = 6;
  localparam int B_CHAIN   = 7;
  localparam int B_MODE    = 0;
  localparam int B_PROT    = 4;
  localparam int C_VERIFY  = 0;
  localparam int C_SWITCH  = 1;
  localparam int C_SOFTRST = 2;
  localparam int S_VERR    = 0;
  localparam int S_LOADED  = 1;
  localparam int S_SWERR   = 2;
  localparam int S_RDERR   = 3;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_LOW  = 2'h1;
  localparam logic [1:0] ERR_HIGH = 2'h3;
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam int WORD_W = 23;
  localparam int TURN_W = 24;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int SSI_CLK_NS = 160;
  localparam int MONO_NS    = 20000;
  localparam logic [11:0] HALF_CYC = 12'(SSI_CLK_NS / (2 * CLK_NS));
  localparam logic [11:0] MONO_CYC = 12'((MONO_NS + CLK_NS - 1) / CLK_NS);

  // Data bits per frame for each format code
  function automatic logic [4:0] emts_fmt_bits(input logic [3:0] f);
    case (f) inside
      4'h0:          return 5'h00;
      [4'h1:4'h6]:   return {1'b0, f};
      [4'h7:4'hA]:   return 5'({1'b0, f} + 5'h08);
      4'hB:          return 5'h04;
      4'hC:          return 5'h08;
      4'hD:          return 5'h0C;
      4'hE:          return 5'h10;
      default:       return 5'h12;
    endcase
  endfunction

  // Low data bits that count as singleturn periods
  function automatic logic [4:0] emts_st_bits(input logic [3:0] f);
    case (f) inside
      [4'h1:4'h6]:   return {1'b0, f};
      [4'h7:4'hA]:   return 5'({1'b0, f} - 5'h04);
      default:       return 5'h00;
    endcase
  endfunction
endpackage

// ### rtl/emts_link_if.sv
// Purpose: Carrier between the controller and the serial frame reader.
// Assumes: One clock; start is a one-cycle pulse while busy is low.
// Notes:   done pulses once with the whole frame in word.
`timescale 1ns/1ns
interface emts_link_if;
  logic        start;
  logic [4:0]  len;
  logic        busy;
  logic        done;
  logic [22:0] word;
  modport ctrl   (output start, len, input busy, done, word);
  modport reader (input start, len, output busy, done, word);
endinterface

// ### rtl/emts_ssi_rx.sv
// Purpose: Clocks one serial frame in from the external sensor.
// Assumes: Sensor shifts a bit out on each rising clock edge.
// Notes:   Clock idles high; a pause follows each frame.
`timescale 1ns/1ns
module emts_ssi_rx import emts_pkg::*; (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  emts_link_if.reader link,
  output logic        ssi_clk_o,
  input  wire logic   ssi_data_i
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_LOW = 4'h2, RX_HIGH = 4'h4, RX_MONO = 4'h8
  } emts_rx_st_t;
  typedef struct packed {
    emts_rx_st_t st;
    logic [11:0] cnt;
    logic [4:0]  bits;
    logic [22:0] sh;
    logic [22:0] word;
    logic        done;
    logic        sclk;
    logic        s1;
    logic        s2;
  } emts_rx_t;
  emts_rx_t q, d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.s1   = ssi_data_i;
    d.s2   = q.s1;
    case (q.st)
      RX_IDLE: begin
        d.sclk = 1'b1;
        if (link.start) begin
          d.bits = link.len;
          d.sh   = '0;
          d.cnt  = HALF_CYC - 12'h001;
          d.sclk = 1'b0;
          d.st   = RX_LOW;
        end
      end
      RX_LOW: begin
        if (q.cnt == 12'h000) begin
          d.sclk = 1'b1;
          d.cnt  = HALF_CYC - 12'h001;
          d.st   = RX_HIGH;
        end else begin
          d.cnt = q.cnt - 12'h001;
        end
      end
      RX_HIGH: begin
        if (q.cnt == 12'h000) begin
          // [R17] MSB first shift
          d.sh   = {q.sh[21:0], q.s2};
          d.bits = q.bits - 5'h01;
          if (q.bits == 5'h01) begin
            d.done = 1'b1;
            d.word = {q.sh[21:0], q.s2};
            d.cnt  = MONO_CYC - 12'h001;
            d.st   = RX_MONO;
          end else begin
            d.sclk = 1'b0;
            d.cnt  = HALF_CYC - 12'h001;
            d.st   = RX_LOW;
          end
        end else begin
          d.cnt = q.cnt - 12'h001;
        end
      end
      RX_MONO: begin
        if (q.cnt == 12'h000) begin
          d.st = RX_IDLE;
        end else begin
          d.cnt = q.cnt - 12'h001;
        end
      end
      default: d.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.st   <= RX_IDLE;
      q.sclk <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ssi_clk_o = q.sclk;
  assign link.busy = (q.st != RX_IDLE);
  assign link.done = q.done;
  assign link.word = q.word;
endmodule

// ### rtl/emts_sync.sv
// Purpose: Turns a raw frame into a synchronized multiturn value.
// Assumes: Frame holds data, sync bits, error bit, right aligned.
// Notes:   Result appears one cycle after valid_i.
`timescale 1ns/1ns
module emts_sync import emts_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        valid_i,
  input  wire logic [22:0] word_i,
  input  wire logic [4:0]  dbits_i,
  input  wire logic [2:0]  sbits_i,
  input  wire logic        ebit_i,
  input  wire logic        high_act_i,
  input  wire logic        inv_i,
  input  wire logic [3:0]  ofs_i,
  input  wire logic [3:0]  ref_i,
  output logic             valid_o,
  output logic [23:0]      value_o,
  output logic             err_o
);
  typedef struct packed {
    logic        valid;
    logic [23:0] value;
    logic        err;
  } emts_sy_t;
  emts_sy_t q, d;
  logic [24:0] mask, full, smask, syn, tref, dlt, corr;

  always_comb begin
    d     = q;
    mask  = (25'h1 << (dbits_i + 5'(sbits_i))) - 25'h1;
    smask = (25'h1 << sbits_i) - 25'h1;
    full  = ebit_i ? {3'h0, word_i[22:1]} : {2'h0, word_i};
    // [R01] direction inversion
    if (inv_i) begin
      full = ~full & mask;
    end
    // [R05] offset before sync
    full  = (full + {{21{ofs_i[3]}}, ofs_i}) & mask;
    syn   = full & smask;
    tref  = {21'h0, ref_i} >> (3'h4 - sbits_i);
    // [R15] sync tolerance window
    dlt   = (tref - syn) & smask;
    if (dlt[sbits_i - 3'h1]) begin
      dlt = dlt - (25'h1 << sbits_i);
    end
    corr    = full + dlt;
    d.valid = valid_i;
    if (valid_i) begin
      d.value = 24'((corr >> sbits_i) & ((25'h1 << dbits_i) - 25'h1));
      // [R02] error bit polarity
      d.err   = ebit_i & (word_i[0] == high_act_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_o = q.valid;
  assign value_o = q.value;
  assign err_o   = q.err;
endmodule

// ### testbench/emts_top_sva.sv
// Purpose: Port-level checks of the external multiturn reader.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached to emts_top by the bind below the module.
`timescale 1ns/1ns
module emts_top_sva import emts_pkg::*; (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ssi_clk_o,
  input wire logic        ssi_data_i,
  input wire logic        st_wrap_up_i,
  input wire logic        st_wrap_dn_i,
  input wire logic [3:0]  st_sync_ref_i,
  input wire logic [23:0] turn_count_o,
  input wire logic [4:0]  st_bits_o,
  input wire logic        turn_valid_o,
  input wire logic        chain_passthrough_enable_o,
  input wire logic [3:0]  port_a_mode_o,
  input wire logic [1:0]  register_protect_level_o,
  input wire logic        irq_o
);
  // ----------------------------------------
  // Bus, link and counter properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd  = req && !wb_we_i;

  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_DAT_BYTE: assert property (wb_ack_o
    && $past(wb_adr_i[9:2]) != IDX_TURN |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_TURN_READ: assert property (rd && wb_adr_i[9:2] == IDX_TURN
    |=> wb_dat_o == {8'h00, $past(turn_count_o)})
    else $error("turn read differs from counter");
  AST_ACT_READ: assert property (rd && wb_adr_i[9:2] == IDX_ACT
    |=> wb_dat_o == {26'h0, $past(register_protect_level_o),
                     $past(port_a_mode_o)})
    else $error("active settings read differs from outputs");
  AST_IEN_OFF: assert property (req && wb_we_i && wb_sel_i[0]
    && wb_adr_i[9:2] == IDX_IEN && wb_dat_i[3:0] == 4'h0 |-> ##3 !irq_o)
    else $error("irq high with all enables off");
  AST_SSI_LOW: assert property ($fell(ssi_clk_o) |->
    (!ssi_clk_o)[*8] ##1 !ssi_clk_o ##1 !ssi_clk_o ##1 ssi_clk_o)
    else $error("serial clock low phase not ten cycles");
  AST_SSI_HIGH: assert property ($rose(ssi_clk_o) |->
    ssi_clk_o[*8] ##1 ssi_clk_o ##1 ssi_clk_o)
    else $error("serial clock high phase too short");
  AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=> ssi_clk_o
    && !wb_ack_o && !irq_o && !turn_valid_o && turn_count_o == 24'h0)
    else $error("outputs not idle after reset");
  AST_ST_BITS: assert property (st_bits_o <= 5'h06)
    else $error("too many singleturn bits");
  AST_WRAP_UP: assert property (turn_valid_o && st_wrap_up_i
    && !st_wrap_dn_i |=> turn_count_o == $past(turn_count_o) + 24'h1)
    else $error("counter missed an upward wrap");
  COV_IRQ: cover property ($rose(irq_o));
  COV_LOAD: cover property ($rose(turn_valid_o));
  COV_FRAME: cover property ($fell(ssi_clk_o));
endmodule
bind emts_top emts_top_sva i_emts_top_sva (.*);

// ### testbench/emts_sensor_model.sv
// Purpose: Behavioural external turn sensor with a serial output.
// Assumes: Frame content and length are set by the bench.
// Notes:   Line is pulled high once the sensor goes idle.
`timescale 1ns/1ns
module emts_sensor_model (
  input  wire logic        clk_i,
  input  wire logic        ssi_clk_i,
  input  wire logic [22:0] word_i,
  input  wire logic [4:0]  len_i,
  output logic             ssi_data_o
);
  logic [22:0] shift_q;
  logic        busy_q = 1'b0;
  logic        sclk_q = 1'b1;
  logic        data_q = 1'b1;
  int          idx_q  = 0;
  int          high_q = 0;
  assign ssi_data_o = data_q;
  // MSB first, one bit per rise
  always @(posedge clk_i) begin
    sclk_q <= ssi_clk_i;
    high_q <= ssi_clk_i ? high_q + 1 : 0;
    if (sclk_q && !ssi_clk_i && !busy_q) begin
      busy_q  <= 1'b1;
      shift_q <= word_i;
      idx_q   <= int'(len_i);
    end else if (!sclk_q && ssi_clk_i && busy_q) begin
      idx_q  <= idx_q - 1;
      data_q <= (idx_q > 0) ? shift_q[idx_q - 1] : ~data_q;
    end else if (busy_q && high_q > 40) begin
      busy_q <= 1'b0;
      data_q <= 1'b1;
    end
  end
endmodule

// ### testbench/external_multiturn_sync_bench.sv
// Purpose: Self-checking bench of the external multiturn reader.
// Assumes: Sensor model answers every frame; one bus master.
// Notes:   Expected turn values come from an integer model.
`timescale 1ns/1ns
module external_multiturn_sync_bench import emts_pkg::*;;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, up = 1'b0, dn = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'hF, rf = 4'h0, pmode;
  logic [31:0] wdat = 32'h0, q, dat_o;
  logic [22:0] word = 23'h0;
  logic [4:0]  len = 5'h00, st_bits;
  logic [1:0]  plev;
  logic [23:0] turn;
  logic        ack, sclk, sdat, tval, chain, irq;
  logic [31:0] seed = 32'h56C8;
  int          n_fail = 0, checked = 0, v, raw;
  logic [7:0]  regs [9] = '{IDX_CFG0, IDX_CFG1, IDX_CFG2, IDX_STAT,
                            IDX_IEN, IDX_PEND, IDX_ACT, IDX_TURN, 8'h3F};
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  emts_top #(.VERIFY_PERIOD_NS(800)) i_emts_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ssi_clk_o(sclk),
    .ssi_data_i(sdat), .st_wrap_up_i(up), .st_wrap_dn_i(dn),
    .st_sync_ref_i(rf), .turn_count_o(turn), .st_bits_o(st_bits),
    .turn_valid_o(tval), .chain_passthrough_enable_o(chain),
    .port_a_mode_o(pmode), .register_protect_level_o(plev), .irq_o(irq));
  emts_sensor_model i_emts_sensor_model (.clk_i(clk_i),
    .ssi_clk_i(sclk), .word_i(word), .len_i(len), .ssi_data_o(sdat));
  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int ev(int w, int d, int s, int inv, int ofs, int r);
    int m, f, dl;
    m = (1 << (d + s)) - 1;
    f = inv ? (~w & m) : w;
    f = (f + ofs) & m;
    dl = ((r >> (4 - s)) - f) & ((1 << s) - 1);
    if (dl >= (1 << (s - 1))) dl = dl - (1 << s);
    return (((f + dl) & m) >> s) & ((1 << d) - 1);
  endfunction
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] ix, input logic w,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    bus(ix, 1'b1, d, q);
  endtask
  task automatic rc(input logic [7:0] ix, input logic [31:0] e,
                    input string m);
    bus(ix, 1'b0, 8'h00, q);
    chk(q, e, m);
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      bus(IDX_STAT, 1'b0, 8'h00, q);
      n++;
    end while (q[b] !== 1'b1 && n < 3000);
    checked++;
    if (n >= 3000) fail("status bit never set");
  endtask
  task automatic irq_is(input logic e, input string m);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, {31'h0, e}, m);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fail("watchdog expired");
    end_sim();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(IDX_ACT, 8'hFF);
    foreach (regs[i]) rc(regs[i], 32'h0, "reset value");
    $display("test reset values done");
    raw = xs() & 32'hFFFFF;
    rf <= 4'(xs());
    word <= {2'h0, raw[19:0], 1'h0};
    len <= 5'h15;
    wr(IDX_CFG0, 8'h40);
    wr(IDX_CFG2, 8'h38);
    wait_st(S_RDERR);
    bus(IDX_STAT, 1'b0, 8'h00, q);
    chk(32'(q[S_LOADED]), 32'h0, "loaded despite error");
    word[0] <= 1'b1;
    wait_st(S_LOADED);
    v = ev(raw, 16, 4, 0, 0, rf);
    rc(IDX_TURN, 32'(v), "startup load");
    chk(32'(tval), 32'h1, "turn valid");
    $display("test startup retry done");
    wr(IDX_PEND, 8'h09);
    wr(IDX_CMD, 8'h02);
    wait_st(S_SWERR);
    wr(IDX_CLR, 8'h0F);
    wr(IDX_PEND, 8'h24);
    wr(IDX_CMD, 8'h02);
    raw = xs() & 32'h1F;
    rf <= 4'(xs());
    word <= {17'h0, raw[4:0], 1'h0};
    len <= 5'h06;
    wr(IDX_CFG0, 8'hE0);
    wr(IDX_CFG1, 8'hB0);
    wr(IDX_CFG2, 8'h13);
    wr(IDX_CMD, 8'h04);
    wr(IDX_CLR, 8'h0F);
    wait_st(S_LOADED);
    chk(32'(q[S_SWERR]), 32'h0, "switch error");
    rc(IDX_ACT, 32'h24, "active settings");
    chk({26'h0, plev, pmode}, 32'h24, "port outputs");
    chk(32'(st_bits), 32'h3, "singleturn bits");
    v = ev(raw, 3, 2, 1, -5, rf);
    rc(IDX_TURN, 32'(v), "inverted offset load");
    $display("test switch and soft reset done");
    wr(IDX_IEN, 8'h01);
    @(posedge clk_i);
    up <= 1'b1;
    @(posedge clk_i);
    up <= 1'b0;
    rc(IDX_TURN, 32'((v + 1) & 24'hFFFFFF), "wrap up");
    word <= {18'h0, raw[4:0]};
    len <= 5'h05;
    wr(IDX_CFG0, 8'h20);
    wr(IDX_CMD, 8'h01);
    wait_st(S_VERR);
    irq_is(1'b1, "irq on mismatch");
    wr(IDX_IEN, 8'h00);
    irq_is(1'b0, "irq masked");
    wr(IDX_IEN, 8'h01);
    irq_is(1'b1, "irq unmasked");
    wr(IDX_CLR, 8'h01);
    irq_is(1'b0, "irq cleared");
    rc(IDX_STAT, 32'h02, "status after clear");
    $display("test verify command done");
    wr(IDX_CFG2, 8'h53);
    wait_st(S_VERR);
    @(posedge clk_i);
    dn <= 1'b1;
    @(posedge clk_i);
    dn <= 1'b0;
    rc(IDX_TURN, 32'(v), "wrap down");
    chk({8'h0, turn}, 32'(v), "turn port");
    wr(IDX_CFG2, 8'h80);
    irq_is(1'b1, "irq stays set");
    chk(32'(chain), 32'h1, "chain passthrough");
    $display("test periodic verify done");
    end_sim();
  end
endmodule
